// ---- src/sbf_top.sv ----
`timescale 1ns/1ns
// Functional notes
// - divisor is (pre+1) times 2^(sel+1)
// - status always readable, writes ignored
// - bit 7 set when receive data lands
// - bit 5 shows transmit register empty
// - bit 4 set on select low as master
// - fault cleared by status read then control one write
// - serial clock is bus clock over divisor
// - baud change in master aborts transfer
// - receive flag cleared by status then low read
// - empty flag cleared by status then low write
module sbf_top
  import sbf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ss_n_in,
  input wire logic miso_in,
  output logic mosi_out,
  output logic sck_out,
  output logic irq
);

  // ***************************************************************
  // registers and state
  // ***************************************************************
  typedef enum {SBF_IDLE, SBF_SHIFT} sbf_state_e;
  sbf_state_e state, next_state;
  logic [7:0] ctrl1, next_ctrl1; // control_register_one
  logic [7:0] ctrl2, next_ctrl2; // mode_fault_enable lives here
  sbf_baud_s baud, next_baud;
  logic rxf, next_rxf; // receive_complete_flag
  logic txe, next_txe; // transmit_empty_flag
  logic mode_fault_flag, next_mode_fault_flag; // mode_fault_flag
  logic rxf_armed, next_rxf_armed; // status seen with rxf set
  logic txe_armed, next_txe_armed;
  logic mode_fault_flag_armed, next_mode_fault_flag_armed;
  logic [7:0] tx_data, next_tx_data; // transmit data register
  logic [7:0] rx_data, next_rx_data; // receive data register
  logic [7:0] tx_hi, next_tx_hi; // high byte, unused in 8-bit width
  logic [7:0] shreg, next_shreg;
  logic [4:0] edges, next_edges; // half-period edges left
  logic sck, next_sck;
  logic [2:0] ev_st, next_ev_st; // sticky events: rx, tx, fault
  logic [2:0] ev_mask, next_ev_mask;
  logic [7:0] rdata, next_rdata;
  logic ss_d, next_ss_d; // previous select level
  logic tick;
  logic restart;
  logic master;
  logic [7:0] status;
  logic wr_baud_change;

  // ***************************************************************
  // baud generator
  // ***************************************************************
  sbf_baud_gen u_baud (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .baud(baud),
    .restart(restart),
    .tick(tick)
  );

  // ***************************************************************
  // combinational next state
  // ***************************************************************
  always_comb
  begin
    master = ctrl1[SBF_BIT_MSTR] & ctrl1[SBF_BIT_SPE];
    status = 8'h00;
    status[SBF_BIT_RXF] = rxf;
    status[SBF_BIT_TXE] = txe;
    status[SBF_BIT_MODE_FAULT_FLAG] = mode_fault_flag;
    wr_baud_change = reg_wr && reg_addr == SBF_OFS_BAUD
      && (reg_wdata[6:4] != baud.pre || reg_wdata[2:0] != baud.sel);
    next_ctrl1 = ctrl1;
    next_ctrl2 = ctrl2;
    next_baud = baud;
    next_rxf = rxf;
    next_txe = txe;
    next_mode_fault_flag = mode_fault_flag;
    next_rxf_armed = rxf_armed;
    next_txe_armed = txe_armed;
    next_mode_fault_flag_armed = mode_fault_flag_armed;
    next_tx_data = tx_data;
    next_rx_data = rx_data;
    next_tx_hi = tx_hi;
    next_shreg = shreg;
    next_edges = edges;
    next_sck = sck;
    next_state = state;
    next_ev_mask = ev_mask;
    next_ss_d = ss_n_in;
    next_rdata = 8'h00;
    restart = 1'b0;
    // software clears first, hardware sets afterwards so sets win
    if (reg_rd)
    begin
      case (reg_addr)
        SBF_OFS_CTRL1: next_rdata = ctrl1;
        SBF_OFS_CTRL2: next_rdata = ctrl2;
        SBF_OFS_BAUD: next_rdata = {1'b0, baud.pre, 1'b0, baud.sel};
        SBF_OFS_STATUS:
        begin
          next_rdata = status;
          next_rxf_armed = rxf;
          next_txe_armed = txe;
          next_mode_fault_flag_armed = mode_fault_flag;
        end
        SBF_OFS_DATA_HI: next_rdata = 8'h00;
        SBF_OFS_DATA_LO:
        begin
          next_rdata = rx_data;
          if (rxf_armed)
          begin
            next_rxf = 1'b0;
            next_rxf_armed = 1'b0;
          end
        end
        SBF_OFS_IRQ_ST: next_rdata = {5'h00, ev_st};
        SBF_OFS_IRQ_MASK: next_rdata = {5'h00, ev_mask};
        default: next_rdata = 8'h00;
      endcase
    end
    if (reg_wr)
    begin
      case (reg_addr)
        SBF_OFS_CTRL1:
        begin
          next_ctrl1 = reg_wdata;
          if (mode_fault_flag_armed)
          begin
            next_mode_fault_flag = 1'b0;
            next_mode_fault_flag_armed = 1'b0;
          end
        end
        SBF_OFS_CTRL2: next_ctrl2 = reg_wdata;
        SBF_OFS_BAUD: next_baud = '{pre: reg_wdata[6:4], sel: reg_wdata[2:0]};
        SBF_OFS_DATA_HI: next_tx_hi = reg_wdata;
        SBF_OFS_DATA_LO:
        begin
          // writes while not empty are dropped
          if (txe && txe_armed)
          begin
            next_tx_data = reg_wdata;
            next_txe = 1'b0;
            next_txe_armed = 1'b0;
          end
        end
        SBF_OFS_IRQ_MASK: next_ev_mask = reg_wdata[2:0];
        default: ; // status: no effect; event status is cleared below
      endcase
    end
    // transfer engine
    case (state)
      SBF_IDLE:
      begin
        next_sck = 1'b0;
        if (master && !next_txe && !txe_armed)
        begin
          next_shreg = tx_data;
          next_txe = 1'b1;
          next_edges = 5'(2 * SBF_XFER_BITS);
          next_state = SBF_SHIFT;
          restart = 1'b1;
        end
      end
      SBF_SHIFT:
      begin
        if (tick)
        begin
          next_sck = ~sck;
          next_edges = edges - 5'h01;
          if (!sck)
          begin
            next_shreg = {shreg[6:0], miso_in};
          end
          if (edges == 5'h01)
          begin
            next_state = SBF_IDLE;
            // a clear in this same cycle lets the new byte land, set wins
            if (!next_rxf)
            begin
              next_rx_data = next_shreg;
              next_rxf = 1'b1;
            end
          end
        end
      end
      default: next_state = SBF_IDLE;
    endcase
    // baud change in master returns to idle
    if (master && wr_baud_change && state == SBF_SHIFT)
    begin
      next_state = SBF_IDLE;
      next_sck = 1'b0;
      restart = 1'b1;
    end
    // mode fault on falling select while master with detection on
    if (master && ctrl2[SBF_BIT_MFEN] && ss_d && !ss_n_in)
    begin
      next_mode_fault_flag = 1'b1;
      next_state = SBF_IDLE;
      next_sck = 1'b0;
      restart = 1'b1;
    end
    // sticky event bits, write one to clear, set wins
    next_ev_st = ev_st;
    if (reg_wr && reg_addr == SBF_OFS_IRQ_ST)
    begin
      next_ev_st = ev_st & ~reg_wdata[2:0];
    end
    next_ev_st = next_ev_st | {next_mode_fault_flag & ~mode_fault_flag, next_txe & ~txe, next_rxf & ~rxf};
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state <= SBF_IDLE;
      ctrl1 <= SBF_RST_CTRL1;
      ctrl2 <= SBF_RST_CTRL2;
      baud <= '0;
      rxf <= 1'b0;
      txe <= 1'b1;
      mode_fault_flag <= 1'b0;
      rxf_armed <= 1'b0;
      txe_armed <= 1'b0;
      mode_fault_flag_armed <= 1'b0;
      tx_data <= 8'h00;
      rx_data <= 8'h00;
      tx_hi <= 8'h00;
      shreg <= 8'h00;
      edges <= 5'h00;
      sck <= 1'b0;
      ev_st <= 3'h0;
      ev_mask <= 3'h0;
      rdata <= 8'h00;
      ss_d <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
      baud <= next_baud;
      rxf <= next_rxf;
      txe <= next_txe;
      mode_fault_flag <= next_mode_fault_flag;
      rxf_armed <= next_rxf_armed;
      txe_armed <= next_txe_armed;
      mode_fault_flag_armed <= next_mode_fault_flag_armed;
      tx_data <= next_tx_data;
      rx_data <= next_rx_data;
      tx_hi <= next_tx_hi;
      shreg <= next_shreg;
      edges <= next_edges;
      sck <= next_sck;
      ev_st <= next_ev_st;
      ev_mask <= next_ev_mask;
      rdata <= next_rdata;
      ss_d <= next_ss_d;
      irq <= |(next_ev_st & next_ev_mask);
    end
  end

  assign reg_rdata = rdata;
  assign sck_out = sck;
  assign mosi_out = shreg[7];

endmodule

// ---- src/sbf_pkg.sv ----
package sbf_pkg;

  // ***************************************************************
  // register offsets (byte addresses on the plain port)
  // ***************************************************************
  localparam logic [2:0] SBF_OFS_CTRL1 = 3'h0; // control_register_one
  localparam logic [2:0] SBF_OFS_CTRL2 = 3'h1; // control two: mode fault enable
  localparam logic [2:0] SBF_OFS_BAUD = 3'h2; // preselect and select fields
  localparam logic [2:0] SBF_OFS_STATUS = 3'h3; // serial_status
  localparam logic [2:0] SBF_OFS_DATA_HI = 3'h4; // data_high_byte
  localparam logic [2:0] SBF_OFS_DATA_LO = 3'h5; // data_low_byte
  localparam logic [2:0] SBF_OFS_IRQ_ST = 3'h6; // sticky event status
  localparam logic [2:0] SBF_OFS_IRQ_MASK = 3'h7; // event mask

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int SBF_BIT_RXF = 7; // receive_complete_flag
  localparam int SBF_BIT_TXE = 5; // transmit_empty_flag
  localparam int SBF_BIT_MODE_FAULT_FLAG = 4; // mode_fault_flag
  localparam int SBF_BIT_MSTR = 4; // master select in control one
  localparam int SBF_BIT_SPE = 6; // enable in control one
  localparam int SBF_BIT_MFEN = 4; // mode_fault_enable in control two
  localparam int SBF_BAUD_PRE_LSB = 4; // preselect at bits 6:4
  localparam int SBF_BAUD_SEL_LSB = 0; // select at bits 2:0

  // ***************************************************************
  // reset values and counts
  // ***************************************************************
  localparam logic [7:0] SBF_RST_CTRL1 = 8'h04;
  localparam logic [7:0] SBF_RST_CTRL2 = 8'h00;
  localparam logic [7:0] SBF_RST_BAUD = 8'h00;
  localparam logic [7:0] SBF_RST_MASK = 8'h00;
  localparam int SBF_XFER_BITS = 8; // bits per transfer
  localparam int SBF_DIV_W = 12; // divisor up to 2048

  // baud fields carried together
  typedef struct packed {
    logic [2:0] pre;
    logic [2:0] sel;
  } sbf_baud_s;

endpackage

// ---- src/sbf_baud_gen.sv ----
`timescale 1ns/1ns
// ***************************************************************
// serial clock half-period generator
// ***************************************************************
module sbf_baud_gen
  import sbf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire sbf_baud_s baud,
  input wire logic restart,
  output logic tick
);

  logic [SBF_DIV_W-1:0] divisor; // full baud divisor
  logic [SBF_DIV_W-1:0] half; // half period in bus cycles
  logic [SBF_DIV_W-1:0] cnt;
  logic [SBF_DIV_W-1:0] next_cnt;
  logic next_tick;

  // divisor = (pre + 1) * 2^(sel + 1), 2 up to 2048
  always_comb
  begin
    // select widened first: a 3-bit sum would wrap to zero at seven
    divisor = SBF_DIV_W'((({9'h000, baud.pre} + 12'h001) << ({1'b0, baud.sel} + 4'h1)));
    half = divisor >> 1;
  end

  // count one half period, restart on transfer start or abort
  always_comb
  begin
    next_tick = 1'b0;
    if (restart)
    begin
      next_cnt = '0;
    end
    else if (cnt + 12'h001 >= half)
    begin
      next_cnt = '0;
      next_tick = 1'b1;
    end
    else
    begin
      next_cnt = cnt + 12'h001;
    end
  end

  // register only
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

// ---- tb/sbf_chk_sva.sv ----
`timescale 1ns/1ns
// ***************************************************************
// port checker
// ***************************************************************
module sbf_chk
  import sbf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ss_n_in,
  input wire logic miso_in,
  input wire logic mosi_out,
  input wire logic sck_out,
  input wire logic irq
);
  logic [7:0] c1, c2, bd, mk; // shadows of written registers
  logic mf, arm; // expected fault flag, clear armed
  logic ab; // abort possible before next rise
  logic [11:0] hc; // cycles in present sck level
  wire mst = c1[6] & c1[4];
  wire st_rd = reg_rd && reg_addr == SBF_OFS_STATUS;
  wire [11:0] half = (12'(bd[6:4]) + 12'h001) << bd[2:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // shadow state; set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      c1 <= SBF_RST_CTRL1;
      c2 <= SBF_RST_CTRL2;
      bd <= SBF_RST_BAUD;
      mk <= SBF_RST_MASK;
      mf <= 1'b0;
      arm <= 1'b0;
      ab <= 1'b1;
      hc <= 12'h000;
    end
    else
    begin
      if (reg_wr && reg_addr == SBF_OFS_CTRL1) c1 <= reg_wdata;
      if (reg_wr && reg_addr == SBF_OFS_CTRL2) c2 <= reg_wdata;
      if (reg_wr && reg_addr == SBF_OFS_BAUD) bd <= reg_wdata;
      if (reg_wr && reg_addr == SBF_OFS_IRQ_MASK) mk <= reg_wdata;
      if ($fell(ss_n_in) && mst && c2[4]) mf <= 1'b1;
      else if (reg_wr && reg_addr == SBF_OFS_CTRL1 && arm) mf <= 1'b0;
      if (st_rd && mf) arm <= 1'b1;
      else if (!mf) arm <= 1'b0;
      // any config write or select low may cut a phase short
      if ((reg_wr && reg_addr < SBF_OFS_STATUS) || !ss_n_in) ab <= 1'b1;
      else if ($rose(sck_out)) ab <= 1'b0;
      hc <= $changed(sck_out) ? 12'h001 : hc + 12'h001;
    end
  end
  AST_HALF_PERIOD: assert property ($fell(sck_out) && !ab |-> hc == half)
    else $error("sck high phase differs from half divisor");
  AST_MODE_FAULT_FLAG_SEEN: assert property ($past(st_rd) |-> reg_rdata[SBF_BIT_MODE_FAULT_FLAG] == $past(mf))
    else $error("mode fault flag wrong");
  AST_BAUD_ABORT: assert property (reg_wr && reg_addr == SBF_OFS_BAUD && mst
    && (reg_wdata & 8'h77) != (bd & 8'h77) |-> ##[1:3] !sck_out [*6]) else $error("baud change did not idle");
  AST_MODE_FAULT_FLAG_ABORT: assert property ($fell(ss_n_in) && mst && c2[4] |-> ##[1:3] !sck_out [*6])
    else $error("fault did not idle");
  AST_TXE_SET: assert property (st_rd && !$past(reg_wr) && !$past(reg_wr, 2)
    |=> reg_rdata[SBF_BIT_TXE]) else $error("transmit empty flag low");
  AST_IRQ_MASK: assert property (mk[2:0] == 3'h0 && $past(mk[2:0]) == 3'h0 |-> !irq)
    else $error("irq with all masked");
  AST_RDATA_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_RST_IDLE: assert property ($past(sys_rst) |-> !sck_out && !irq && !mosi_out)
    else $error("outputs not idle after reset");
  cover property ($fell(sck_out) && !ab);
  cover property (st_rd && mf);
  cover property ($rose(irq));
endmodule

bind sbf_top sbf_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ss_n_in(ss_n_in),
  .miso_in(miso_in), .mosi_out(mosi_out), .sck_out(sck_out), .irq(irq));

// ---- tb/sbf_peer.sv ----
`timescale 1ns/1ns
// ***************************************************************
// far-side peripheral model
// ***************************************************************
module sbf_peer #(parameter logic [7:0] PAT = 8'h5a)
(
  input wire logic clr,
  input wire logic sck_out,
  output logic miso_in,
  output logic [3:0] rises
);
  // count rising serial clock edges of one frame
  always @(posedge sck_out or posedge clr)
  begin
    if (clr)
      rises <= 4'h0;
    else
      rises <= rises + 4'h1;
  end
  // msb waits before the first rise, next bit moves on each fall so
  // the master's rising-edge sample never races the change
  always @(negedge sck_out or posedge clr)
  begin
    if (clr)
      miso_in <= PAT[7];
    else
      miso_in <= PAT[~rises[2:0]];
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
// ***************************************************************
// bench top
// ***************************************************************
module tb_top;
  import sbf_pkg::*;
  logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ss_n_in = 1, clr = 1, rd_d = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic sck_out, mosi_out, irq, miso_in;
  logic [3:0] rises;
  logic [7:0] eq[$], mq[$]; // expected reads and masks
  int errors = 0, checks = 0, half, t;
  always #25 ref_clk = ~ref_clk;
  sbf_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ss_n_in(ss_n_in), .miso_in(miso_in),
    .mosi_out(mosi_out), .sck_out(sck_out), .irq(irq));
  sbf_peer PEER (.clr(clr), .sck_out(sck_out), .miso_in(miso_in), .rises(rises));
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (e !== s)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // note the expectation first, then issue the read
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    eq.push_back(e & m);
    mq.push_back(m);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    clr <= 1'b0;
  endtask
  // read data stands one cycle: sample it mid-cycle
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk)
  begin
    if (rd_d)
      cmp("reg_rdata", {8'h00, eq.pop_front()}, {8'h00, reg_rdata & mq.pop_front()});
  end
  // one whole byte at baud setting b
  task automatic xfer(input logic [7:0] b, input logic [7:0] d);
    half = (b[6:4] + 1) << b[2:0];
    wr(SBF_OFS_BAUD, b);
    idle(10);
    clr <= 1'b1;
    rd(SBF_OFS_STATUS, 8'h20);
    wr(SBF_OFS_DATA_LO, d);
    t = 0;
    while (!irq && t < 16 * half + 40)
    begin
      @(posedge ref_clk);
      t++;
    end
    cmp("xfer_time_ok", 16'h0001, (t >= 16 * half - 2) && (t <= 16 * half + 8));
    cmp("sck_rises", 16'h0008, rises);
    rd(SBF_OFS_STATUS, 8'ha0);
    rd(SBF_OFS_DATA_HI, 8'h00);
    rd(SBF_OFS_STATUS, 8'ha0);
    rd(SBF_OFS_DATA_LO, 8'h5a);
    rd(SBF_OFS_STATUS, 8'h20);
    wr(SBF_OFS_IRQ_ST, 8'h07);
    idle(2);
    cmp("irq", 16'h0000, irq);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(24));
    idle(20);
    sys_rst <= 1'b0;
    rd(SBF_OFS_CTRL1, SBF_RST_CTRL1);
    wr(SBF_OFS_STATUS, 8'hff);
    rd(SBF_OFS_STATUS, 8'h20);
    wr(SBF_OFS_CTRL1, 8'h54);
    wr(SBF_OFS_IRQ_MASK, 8'h01);
    xfer(8'h00, 8'h3c);
    xfer(8'h77, 8'hc3);
    repeat (3) xfer(8'($urandom) & 8'h53, 8'($urandom));
    // baud change mid-byte must drop to idle
    wr(SBF_OFS_BAUD, 8'h11);
    idle(10);
    clr <= 1'b1;
    rd(SBF_OFS_STATUS, 8'h20);
    wr(SBF_OFS_DATA_LO, 8'($urandom));
    idle(10);
    wr(SBF_OFS_BAUD, 8'h12);
    idle(400);
    cmp("rises_short", 16'h0001, rises < 4'h8);
    rd(SBF_OFS_STATUS, 8'h20);
    // mode fault, then masking and the two-step clear
    wr(SBF_OFS_CTRL2, 8'h10);
    wr(SBF_OFS_IRQ_MASK, 8'h04);
    // fault lands while the serial clock is high mid-byte
    rd(SBF_OFS_STATUS, 8'h20);
    wr(SBF_OFS_DATA_LO, 8'($urandom));
    idle(12);
    ss_n_in <= 1'b0;
    idle(5);
    cmp("sck_fault", 16'h0000, sck_out);
    ss_n_in <= 1'b1;
    idle(3);
    cmp("irq", 16'h0001, irq);
    wr(SBF_OFS_IRQ_MASK, 8'h00);
    idle(2);
    cmp("irq", 16'h0000, irq);
    wr(SBF_OFS_IRQ_ST, 8'h07);
    wr(SBF_OFS_CTRL1, 8'h54);
    rd(SBF_OFS_STATUS, 8'h30);
    wr(SBF_OFS_CTRL1, 8'h54);
    idle(2);
    rd(SBF_OFS_STATUS, 8'h20);
    idle(4);
    complete_run;
  end
  // watchdog well beyond the slowest byte
  initial
  begin
    idle(60000);
    errors++;
    complete_run;
  end
endmodule
